// File: core/bftg_divider.sv
`timescale 1ns/100ps
module bftg_divider
    import bftg_pkg::*;
#(
    parameter int W = 16
)(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         en_i,
    input  wire logic         clr_i,
    input  wire logic [W-1:0] limit_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_q;

    // Pulses once every limit_i enabled cycles
    always_ff @(posedge clk_i)
    begin
        if (rst_i || clr_i)
        begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end
        else if (en_i)
        begin
            if (cnt_q + W'(1) >= limit_i)
            begin
                cnt_q  <= '0;
                tick_o <= 1'b1;
            end
            else
            begin
                cnt_q  <= cnt_q + W'(1);
                tick_o <= 1'b0;
            end
        end
        else
        begin
            tick_o <= 1'b0;
        end
    end
endmodule : bftg_divider

// File: core/bftg_pkg.sv
package bftg_pkg;
    // Register byte addresses
    localparam logic [7:0]  BFTG_CFG_ADDR      = 8'h00;
    localparam logic [7:0]  BFTG_STAT_ADDR     = 8'h04;
    localparam logic [7:0]  BFTG_MASK_ADDR     = 8'h08;
    localparam logic [7:0]  BFTG_CTRL_ADDR     = 8'h0c;
    // Config fields
    localparam int          BFTG_DIS_BIT       = 15;
    localparam int          BFTG_FREQUENCY_DIVIDER_LSB      = 8;
    localparam int          BFTG_FREQUENCY_DIVIDER_W        = 7;
    localparam int          BFTG_DUR_LSB       = 0;
    localparam int          BFTG_DUR_W         = 8;
    localparam logic [15:0] BFTG_CFG_RST       = 16'h0000;
    // Status / mask fields
    localparam int          BFTG_STARTED_BIT   = 10;
    localparam int          BFTG_ENDED_BIT     = 11;
    localparam int          BFTG_PLAYING_BIT   = 0;
    localparam logic [15:0] BFTG_MASK_RST      = 16'h0000;
    localparam logic [15:0] BFTG_FLAG_MASK     = 16'h0c00;
    // Control fields
    localparam int          BFTG_START_BIT     = 0;
    localparam int          BFTG_MODE_BIT      = 1;
    localparam int          BFTG_STOP_BIT      = 2;
    // Special values
    localparam logic [7:0]  BFTG_DUR_INFINITE  = 8'hff;
    localparam logic [7:0]  BFTG_DUR_ZERO      = 8'h00;
    localparam logic [6:0]  BFTG_FREQUENCY_DIVIDER_MIN      = 7'h04;
    // Timing
    localparam int          BFTG_CLK_HZ        = 20000000;
    localparam int          BFTG_TONE_CLK_HZ   = 32768;
    localparam int          BFTG_STEP_MS       = 4;
    localparam int          BFTG_TONE_DIV      = BFTG_CLK_HZ / BFTG_TONE_CLK_HZ;
    localparam int          BFTG_STEP_TICKS    = BFTG_TONE_CLK_HZ * BFTG_STEP_MS / 1000;

    typedef enum logic [1:0] {
        BFTG_IDLE = 2'b00,
        BFTG_PLAY = 2'b01
    } bftg_state_t;
endpackage : bftg_pkg

// File: core/bftg_tone.sv
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - Tone plays first in sequence, alone in pulse
// - Disable bit holds both pins low
// - Disable bit changes act immediately
// - Frequency 0..3 is a silent rest
// - Frequency 4..127 divides the 32.768 kHz clock
// - Frequency writes act immediately
// - Duration counts in 4 ms steps
// - Writing duration zero ends tone now
// - Duration all-ones plays until stopped
// - Other duration writes apply next start
// - Sticky started/ended flags, write-one clear
module bftg_tone
    import bftg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        seq_start_i,
    input  wire logic        seq_stop_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             err_o,
    output logic             irq_o,
    output logic             playing_o,
    output logic             tone_started_o,
    output logic             tone_ended_o,
    output logic             beep_p_o,
    output logic             beep_n_o
);
    localparam int SW = $clog2(BFTG_STEP_TICKS + 1);

    logic [15:0] cfg_q;
    logic [15:0] mask_q;
    logic        started_q;
    logic        ended_q;
    logic        mode_pulse_q;
    bftg_state_t state_q;
    logic [7:0]  dur_left_q;
    logic        infinite_q;
    logic [6:0]  half_cnt_q;
    logic        phase_q;
    logic        tone_tick;
    logic        step_tick;
    logic        req;
    logic        wr;
    logic        rd_stat;
    logic        start_ev;
    logic        stop_ev;
    logic        kill_ev;
    logic        expire_ev;
    logic        end_ev;
    logic        playing;
    logic [6:0]  frequency_divider;
    logic        rest;
    logic [15:0] stat_view;
    logic [15:0] cfg_next;
    logic [15:0] mask_next;
    logic [15:0] rd_data;
    logic [7:0]  dur_field;
    logic        dur_zero;
    logic        wr_cfg;
    logic        wr_mask;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        start_cmd;
    logic        stop_cmd;
    logic        clr_started;
    logic        clr_ended;
    logic [6:0]  half_len;
    logic        sounding;

    assign req      = cyc_i && stb_i && !ack_o && !err_o;
    assign wr       = req && we_i;
    assign rd_stat  = req && !we_i && adr_i == BFTG_STAT_ADDR;
    assign playing  = state_q == BFTG_PLAY;
    assign frequency_divider     = cfg_q[BFTG_FREQUENCY_DIVIDER_LSB +: BFTG_FREQUENCY_DIVIDER_W];
    assign rest     = frequency_divider < BFTG_FREQUENCY_DIVIDER_MIN;
    assign dur_field = cfg_q[BFTG_DUR_LSB +: BFTG_DUR_W];
    assign dur_zero  = dat_i[BFTG_DUR_LSB +: BFTG_DUR_W] == BFTG_DUR_ZERO;
    assign sounding  = playing && !rest && !cfg_q[BFTG_DIS_BIT];

    // Decoded write strobes
    assign wr_cfg      = wr && adr_i == BFTG_CFG_ADDR;
    assign wr_mask     = wr && adr_i == BFTG_MASK_ADDR;
    assign wr_ctrl     = wr && adr_i == BFTG_CTRL_ADDR;
    assign wr_stat     = wr && adr_i == BFTG_STAT_ADDR;
    assign start_cmd   = wr_ctrl && sel_i[0] && dat_i[BFTG_START_BIT];
    assign stop_cmd    = wr_ctrl && sel_i[0] && dat_i[BFTG_STOP_BIT];
    assign clr_started = rd_stat || (wr_stat && sel_i[1] && dat_i[BFTG_STARTED_BIT]);
    assign clr_ended   = rd_stat || (wr_stat && sel_i[1] && dat_i[BFTG_ENDED_BIT]);

    // Byte-lane merge for the config register
    always_comb
    begin
        cfg_next = cfg_q;
        if (sel_i[0])
            cfg_next[7:0] = dat_i[7:0];
        if (sel_i[1])
            cfg_next[15:8] = dat_i[15:8];
    end

    // Byte-lane merge for the mask register
    always_comb
    begin
        mask_next = mask_q;
        if (sel_i[0])
            mask_next[7:0] = dat_i[7:0];
        if (sel_i[1])
            mask_next[15:8] = dat_i[15:8];
    end

    // Register read multiplexer
    always_comb
    begin
        case (adr_i)
            BFTG_CFG_ADDR:  rd_data = cfg_q;
            BFTG_STAT_ADDR: rd_data = stat_view;
            BFTG_MASK_ADDR: rd_data = mask_q;
            BFTG_CTRL_ADDR:
            begin
                rd_data = 16'h0000;
                rd_data[BFTG_MODE_BIT] = mode_pulse_q;
            end
            default:        rd_data = 16'h0000;
        endcase
    end

    // Half period in tone ticks; an odd divider gets the longer half high
    assign half_len = phase_q ? frequency_divider - (frequency_divider >> 1) : frequency_divider >> 1;

    // Software start from control register, or sequencer start
    assign start_ev = !playing && dur_field != BFTG_DUR_ZERO
                      && (seq_start_i || start_cmd);
    assign kill_ev  = playing && wr_cfg && sel_i[0] && dur_zero;
    assign stop_ev  = playing && (seq_stop_i || stop_cmd);
    assign expire_ev = playing && !infinite_q && step_tick && dur_left_q <= 8'h01;
    assign end_ev   = kill_ev || stop_ev || expire_ev;

    // 32.768 kHz enable from the system clock
    bftg_divider #(.W(16)) u_tone_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (1'b1),
        .clr_i   (1'b0),
        .limit_i (16'(BFTG_TONE_DIV)),
        .tick_o  (tone_tick)
    );

    // 4 ms step enable, restarted with the tone
    bftg_divider #(.W(SW)) u_step_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .en_i    (tone_tick),
        .clr_i   (start_ev),
        .limit_i (SW'(BFTG_STEP_TICKS)),
        .tick_o  (step_tick)
    );

    // Bus handshake
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end
        else
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            if (req)
            begin
                case (adr_i)
                    BFTG_CFG_ADDR, BFTG_STAT_ADDR, BFTG_MASK_ADDR, BFTG_CTRL_ADDR:
                        ack_o <= 1'b1;
                    default:
                        err_o <= 1'b1;
                endcase
            end
        end
    end

    // Read data, captured with the answer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (req)
            dat_o <= {16'h0000, rd_data};
    end

    always_comb
    begin
        stat_view = 16'h0000;
        stat_view[BFTG_STARTED_BIT] = started_q;
        stat_view[BFTG_ENDED_BIT]   = ended_q;
        stat_view[BFTG_PLAYING_BIT] = playing;
    end

    // Config and mask registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_q  <= BFTG_CFG_RST;
            mask_q <= BFTG_MASK_RST;
        end
        else
        begin
            if (wr_cfg)
                cfg_q <= cfg_next;
            if (wr_mask)
                mask_q <= mask_next & BFTG_FLAG_MASK;
        end
    end

    // Pulse-mode bit, stored for the sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_pulse_q <= 1'b0;
        else if (wr_ctrl && sel_i[0])
            mode_pulse_q <= dat_i[BFTG_MODE_BIT];
    end

    // Sticky flags: set wins over clear; write-one or status read clears
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            started_q <= 1'b0;
            ended_q   <= 1'b0;
        end
        else
        begin
            if (start_ev)
                started_q <= 1'b1;
            else if (clr_started)
                started_q <= 1'b0;
            if (end_ev)
                ended_q <= 1'b1;
            else if (clr_ended)
                ended_q <= 1'b0;
        end
    end

    // Tone duration state machine
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q    <= BFTG_IDLE;
            dur_left_q <= 8'h00;
            infinite_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                BFTG_IDLE:
                    if (start_ev)
                    begin
                        state_q    <= BFTG_PLAY;
                        dur_left_q <= dur_field;
                        infinite_q <= dur_field == BFTG_DUR_INFINITE;
                    end
                BFTG_PLAY:
                    if (end_ev)
                        state_q <= BFTG_IDLE;
                    else if (step_tick && !infinite_q)
                        dur_left_q <= dur_left_q - 8'h01;
                default:
                    state_q <= BFTG_IDLE;
            endcase
        end
    end

    // Oscillator: half period counts the divided clock
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !playing || rest)
        begin
            half_cnt_q <= 7'h00;
            phase_q    <= 1'b0;
        end
        else if (tone_tick)
        begin
            if (half_cnt_q + 7'h01 >= half_len)
            begin
                half_cnt_q <= 7'h00;
                phase_q    <= ~phase_q;
            end
            else
            begin
                half_cnt_q <= half_cnt_q + 7'h01;
            end
        end
    end

    // Pins, registered; both low unless sounding
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            beep_p_o <= 1'b0;
            beep_n_o <= 1'b0;
        end
        else if (!sounding)
        begin
            beep_p_o <= 1'b0;
            beep_n_o <= 1'b0;
        end
        else
        begin
            beep_p_o <= phase_q;
            beep_n_o <= ~phase_q;
        end
    end

    // Interrupt level from unmasked sticky flags
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= (started_q && mask_q[BFTG_STARTED_BIT])
                     || (ended_q && mask_q[BFTG_ENDED_BIT]);
    end

    // Playing level and tone event pulses for the sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            playing_o      <= 1'b0;
            tone_started_o <= 1'b0;
            tone_ended_o   <= 1'b0;
        end
        else
        begin
            playing_o      <= playing;
            tone_started_o <= start_ev;
            tone_ended_o   <= end_ev;
        end
    end
endmodule : bftg_tone

// File: tb/bftg_piezo.sv
`timescale 1ns/100ps
module bftg_piezo (
    input  wire logic  clk_i,
    input  wire logic  pin_a_i,
    input  wire logic  pin_b_i,
    output logic [15:0] edges_o,
    output logic        dc_o
);
    logic last_q = 1'b0;
    initial edges_o = 16'h0000;
    initial dc_o = 1'b0;
    // Counts swings of one plate, flags a DC bias across both
    always @(posedge clk_i)
    begin
        last_q <= pin_a_i;
        if (pin_a_i !== last_q)
            edges_o <= edges_o + 16'h0001;
        if (pin_a_i === 1'b1 && pin_b_i === 1'b1)
            dc_o <= 1'b1;
    end
endmodule : bftg_piezo

// File: tb/bftg_tone_chk.sv
`timescale 1ns/100ps
module bftg_tone_chk
    import bftg_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] adr_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       seq_stop_i,
    input wire logic       ack_o,
    input wire logic       err_o,
    input wire logic       playing_o,
    input wire logic       tone_started_o,
    input wire logic       tone_ended_o,
    input wire logic       beep_p_o,
    input wire logic       beep_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic hit;
    assign req = cyc_i && stb_i && !ack_o && !err_o;
    assign hit = adr_i inside {BFTG_CFG_ADDR, BFTG_STAT_ADDR, BFTG_MASK_ADDR, BFTG_CTRL_ADDR};
    property p_ack; req && hit |=> ack_o && !err_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_err; req && !hit |=> err_o && !ack_o; endproperty
    a_err: assert property (p_err) else $error("err missing");
    property p_drop; ack_o || err_o |=> !ack_o && !err_o; endproperty
    a_drop: assert property (p_drop) else $error("answer held");
    property p_anti; beep_p_o |-> !beep_n_o; endproperty
    a_anti: assert property (p_anti) else $error("pins both high");
    property p_idle; (!playing_o)[*3] |-> !beep_p_o && !beep_n_o; endproperty
    a_idle: assert property (p_idle) else $error("pins active when idle");
    property p_start; tone_started_o |-> ##[0:2] playing_o; endproperty
    a_start: assert property (p_start) else $error("start without play");
    property p_end; tone_ended_o |-> ##[0:2] !playing_o; endproperty
    a_end: assert property (p_end) else $error("end while playing");
    property p_stop; seq_stop_i && playing_o |-> ##[1:3] !playing_o; endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    c_start: cover property (tone_started_o);
    c_end: cover property (tone_ended_o);
    c_err: cover property (err_o);
endmodule : bftg_tone_chk

// File: tb/bftg_tone_tb_top.sv
`timescale 1ns/100ps
module bftg_tone_tb_top import bftg_pkg::*;;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
    logic        seq_start_i = 0, seq_stop_i = 0, dc;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rs = 32'had85;
    logic [3:0]  sel_i = 4'h0;
    logic        ack_o, err_o, irq_o, playing_o, tone_started_o, tone_ended_o;
    logic        beep_p_o, beep_n_o;
    logic [15:0] edges, e0;
    logic [33:0] exp_q[$], x;
    logic [6:0]  f;
    int          errors = 0, compares = 0, n;
    always #25 clk_i = ~clk_i;
    bftg_tone dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .seq_start_i(seq_start_i),
        .seq_stop_i(seq_stop_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq_o(irq_o),
        .playing_o(playing_o), .tone_started_o(tone_started_o), .tone_ended_o(tone_ended_o),
        .beep_p_o(beep_p_o), .beep_n_o(beep_n_o));
    bftg_piezo u_piezo (.clk_i(clk_i), .pin_a_i(beep_p_o), .pin_b_i(beep_n_o),
        .edges_o(edges), .dc_o(dc));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    function automatic logic [31:0] cfg(input logic d, input logic [6:0] q, input logic [7:0] u);
        return {16'h0000, d, q, u};
    endfunction : cfg
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1)
        begin
            errors++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e);
        int k;
        k = 0;
        exp_q.push_back({!(a inside {8'h00, 8'h04, 8'h08, 8'h0c}), w, e});
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'h3;
        tick(1);
        while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20)
        begin
            tick(1);
            k++;
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        chk(k < 20, "bus timeout");
    endtask : wb
    // One full period of the plus pin, measured after a first swing
    task automatic per(output int c);
        logic p;
        int   s;
        int   g;
        c = 0;
        g = 0;
        for (s = 0; s < 3; s++)
        begin
            p = beep_p_o;
            while (beep_p_o === p && g < 12000)
            begin
                tick(1);
                g++;
                if (s > 0)
                    c++;
            end
        end
    endtask : per
    task automatic wrap_up;
        $display("Compares %0d, errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    always @(posedge clk_i)
    begin
        if (ack_o === 1'b1 || err_o === 1'b1)
        begin
            x = exp_q.pop_front();
            chk(err_o === x[33] && (x[32] || dat_o === x[31:0]), "bus answer");
        end
    end
    initial
    begin
        tick(120000);
        errors++;
        wrap_up;
    end
    initial
    begin
        tick(5);
        rst_i <= 1'b0;
        wb(0, BFTG_CFG_ADDR, 0, 32'h0);
        wb(0, BFTG_MASK_ADDR, 0, 32'h0);
        wb(0, 8'h10, 0, 32'h0);
        wb(1, BFTG_MASK_ADDR, 32'h800, 0);
        wb(0, BFTG_MASK_ADDR, 0, 32'h800);
        rs = xs(rs);
        f = 7'h04 + {5'h00, rs[1:0]};
        wb(1, BFTG_CFG_ADDR, cfg(0, f, 8'hff), 0);
        wb(0, BFTG_CFG_ADDR, 0, cfg(0, f, 8'hff));
        wb(1, BFTG_CTRL_ADDR, 32'h1, 0);
        wb(0, BFTG_STAT_ADDR, 0, 32'h401);
        per(n);
        chk(n == f * BFTG_TONE_DIV, "period");
        chk(beep_n_o === ~beep_p_o, "antiphase");
        wb(1, BFTG_CFG_ADDR, cfg(0, 7'h08, 8'hff), 0);
        per(n);
        chk(n == 8 * BFTG_TONE_DIV, "divider change");
        wb(1, BFTG_CFG_ADDR, cfg(1, 7'h08, 8'hff), 0);
        tick(3);
        e0 = edges;
        chk(beep_p_o === 1'b0 && beep_n_o === 1'b0, "disable");
        tick(2500);
        chk(edges === e0 && playing_o === 1'b1, "held low");
        wb(1, BFTG_CFG_ADDR, cfg(0, 7'h08, 8'h05), 0);
        tick(2500);
        chk(edges !== e0 && playing_o === 1'b1, "duration write");
        wb(1, BFTG_CFG_ADDR, cfg(0, 7'h08, 8'h00), 0);
        tick(3);
        chk(playing_o === 1'b0 && irq_o === 1'b1, "terminate");
        wb(0, BFTG_STAT_ADDR, 0, 32'h800);
        tick(3);
        chk(irq_o === 1'b0, "irq clear");
        rs = xs(rs);
        wb(1, BFTG_CFG_ADDR, cfg(0, {5'h00, rs[1:0]}, 8'hff), 0);
        seq_start_i <= 1'b1;
        tick(1);
        seq_start_i <= 1'b0;
        tick(3);
        e0 = edges;
        chk(playing_o === 1'b1, "sequencer start");
        tick(1500);
        chk(edges === e0 && playing_o === 1'b1, "rest tone");
        seq_stop_i <= 1'b1;
        tick(1);
        seq_stop_i <= 1'b0;
        tick(3);
        chk(playing_o === 1'b0, "stop");
        wb(0, BFTG_STAT_ADDR, 0, 32'hc00);
        wb(1, BFTG_CFG_ADDR, cfg(0, 7'h04, 8'h01), 0);
        wb(1, BFTG_CTRL_ADDR, 32'h1, 0);
        tick(78000);
        chk(playing_o === 1'b1, "one step running");
        tick(2100);
        chk(playing_o === 1'b0, "one step over");
        chk(dc === 1'b0, "dc bias");
        wrap_up;
    end
endmodule : bftg_tone_tb_top
bind bftg_tone bftg_tone_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .seq_stop_i(seq_stop_i), .ack_o(ack_o), .err_o(err_o),
    .playing_o(playing_o), .tone_started_o(tone_started_o), .tone_ended_o(tone_ended_o),
    .beep_p_o(beep_p_o), .beep_n_o(beep_n_o));
